/* src/rct_pkg.sv */
// shared constants and carrier types of the countdown timer
package rct_pkg;

	// register indices and byte addresses (four bytes per index)
	localparam logic [7:0] RCT_IDX_TVAL   = 8'h10;
	localparam logic [7:0] RCT_IDX_TMODE  = 8'h11;
	localparam logic [7:0] RCT_IDX_STAT   = 8'h12;
	localparam logic [7:0] RCT_ADDR_TVAL  = 8'(RCT_IDX_TVAL * 4);
	localparam logic [7:0] RCT_ADDR_TMODE = 8'(RCT_IDX_TMODE * 4);
	localparam logic [7:0] RCT_ADDR_STAT  = 8'(RCT_IDX_STAT * 4);
	localparam int         RCT_AW         = 8;
	localparam int         RCT_DW         = 32;

	// field positions
	localparam int RCT_SEL_LSB  = 3;
	localparam int RCT_SEL_MSB  = 4;
	localparam int RCT_RUN_BIT  = 2;
	localparam int RCT_IEN_BIT  = 1;
	localparam int RCT_PSEL_BIT = 0;
	localparam int RCT_FLAG_BIT = 0;

	// reset values
	localparam logic [1:0] RCT_SEL_RST  = 2'h3;
	localparam logic       RCT_BIT_RST  = 1'h0;
	localparam logic [7:0] RCT_TVAL_RST = 8'h00;

	// source select codes
	localparam logic [1:0] RCT_SRC_4096 = 2'h0;
	localparam logic [1:0] RCT_SRC_64   = 2'h1;
	localparam logic [1:0] RCT_SRC_1    = 2'h2;
	localparam logic [1:0] RCT_SRC_60TH = 2'h3;

	// oscillator and derived rates
	localparam int RCT_OSC_HZ   = 32768;
	localparam int RCT_DIV_4096 = RCT_OSC_HZ / 4096;
	localparam int RCT_DIV_64   = RCT_OSC_HZ / 64;
	localparam int RCT_DIV_1    = RCT_OSC_HZ / 1;
	localparam int RCT_SEC_MIN  = 60;

	// interrupt pulse widths in oscillator ticks
	localparam int RCT_PW_FAST_T1 = RCT_OSC_HZ / 8192;
	localparam int RCT_PW_FAST    = RCT_OSC_HZ / 4096;
	localparam int RCT_PW_64_T1   = RCT_OSC_HZ / 128;
	localparam int RCT_PW_64      = RCT_OSC_HZ / 64;
	localparam int RCT_PW_SLOW    = RCT_OSC_HZ / 64;
	localparam int RCT_PW_W       = $clog2(RCT_PW_SLOW + 1);

	typedef struct packed {
		logic osc;
		logic f4096;
		logic f64;
		logic f1;
		logic f60;
	} rct_ticks_t;

	typedef struct packed {
		logic [1:0] src_sel;
		logic       run;
		logic       irq_en;
		logic       pulse_sel;
	} rct_mode_t;

endpackage

/* src/rct_sync2.sv */
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
module rct_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_resetn,
	// async in, synced out
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_reg <= '0;
			o_sync   <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule // rct_sync2

/* src/rct_tick_gen.sv */
// divides oscillator edges into the four timer source ticks
`timescale 1ns/100ps
module rct_tick_gen
	import rct_pkg::*;
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_resetn,
	// oscillator edge and offset correction pulses
	input  wire logic i_osc_edge,
	input  wire logic i_corr_add,
	input  wire logic i_corr_drop,
	// one-cycle source ticks
	output rct_ticks_t o_ticks
);
	localparam int FW = $clog2(RCT_DIV_64);
	localparam int SW = $clog2(RCT_DIV_1) + 2;
	localparam int MW = $clog2(RCT_SEC_MIN);

	logic [FW-1:0] fast_reg;
	logic [SW-1:0] slow_reg;
	logic [SW-1:0] slow_next;
	logic [MW-1:0] min_reg;
	logic          add_pend_reg;
	logic          drop_pend_reg;
	logic          sec_tick;

	// corrections wait for the next oscillator edge; a new one wins
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			add_pend_reg  <= 1'b0;
			drop_pend_reg <= 1'b0;
		end else begin
			add_pend_reg  <= i_corr_add | (add_pend_reg & ~i_osc_edge);
			drop_pend_reg <= i_corr_drop | (drop_pend_reg & ~i_osc_edge);
		end
	end

	// fast chain sees raw oscillator only
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			fast_reg <= '0;
		else if (i_osc_edge)
			fast_reg <= FW'(fast_reg + 1'b1);
	end

	// slow chain steps 0, 1 or 2 per edge so corrections stretch or shorten seconds
	always_comb begin
		slow_next = SW'(slow_reg + 1'b1 + add_pend_reg - drop_pend_reg);
		sec_tick  = 1'b0;
		if (slow_next >= SW'(RCT_DIV_1)) begin
			slow_next = SW'(slow_next - SW'(RCT_DIV_1));
			sec_tick  = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			slow_reg <= '0;
			min_reg  <= '0;
		end else if (i_osc_edge) begin
			slow_reg <= slow_next;
			if (sec_tick)
				min_reg <= (min_reg == MW'(RCT_SEC_MIN - 1)) ? '0 :
					MW'(min_reg + 1'b1);
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ticks <= '0;
		end else begin
			o_ticks.osc   <= i_osc_edge;
			o_ticks.f4096 <= i_osc_edge &
				(fast_reg[2:0] == 3'(RCT_DIV_4096 - 1));
			o_ticks.f64   <= i_osc_edge & (fast_reg == FW'(RCT_DIV_64 - 1));
			o_ticks.f1    <= i_osc_edge & sec_tick;
			o_ticks.f60   <= i_osc_edge & sec_tick &
				(min_reg == MW'(RCT_SEC_MIN - 1));
		end
	end

	corr_drop_a: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		i_osc_edge && drop_pend_reg && !add_pend_reg |=> $stable(slow_reg))
		else $error("drop correction did not hold the count");
endmodule // rct_tick_gen

/* src/rct_countdown_timer.sv */
// countdown timer with APB registers and interrupt output
// Overview of operation
// - source select picks 4096, 64, 1, 1/60 Hz
// - eight-bit down count; zero reload stops it
// - expiry from one sets flag and reloads
// - reload write loads the counter at once
// - new reload value kept for later periods
// - first period after run gains sync slack
// - later periods last exactly reload ticks
// - flag stays set until software clears it
// - pulse select and interrupt enable shape output
// - flag and interrupt assert in same edge
// - pulse width follows source rate and reload
// - count register reads the live count
// - slow sources include offset correction pulses
// - value at index 10h, control at 11h
// - pulse select zero follows flag, one pulses; code holds irq high while run is off
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module rct_countdown_timer
	import rct_pkg::*;
(
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_resetn,
	// apb slave
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [RCT_AW-1:0] i_paddr,
	input  wire logic [RCT_DW-1:0] i_pwdata,
	output logic      [RCT_DW-1:0] o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	// oscillator pin and offset correction
	input  wire logic              i_osc_32k,
	input  wire logic              i_corr_add,
	input  wire logic              i_corr_drop,
	// interrupt and flag
	output logic                   o_irq_n,
	output logic                   o_countdown_flag
);
	logic                  osc_sync;
	logic                  osc_prev_reg;
	logic                  osc_edge;
	rct_ticks_t            ticks;
	rct_mode_t             mode_reg;
	logic [7:0]            reload_reg;
	logic [7:0]            count_reg;
	logic                  armed_reg;
	logic                  flag_reg;
	logic                  flag_next;
	logic [RCT_PW_W-1:0]   pulse_reg;
	logic [RCT_PW_W-1:0]   pulse_next;
	logic [RCT_PW_W-1:0]   pulse_width;
	logic                  src_tick;
	logic                  sync_tick;
	logic                  expire;
	logic                  setup;
	logic                  commit;
	logic                  mapped;
	logic                  wr_tval;
	logic                  wr_tmode;
	logic                  wr_stat;
	logic [RCT_DW-1:0]     rdata;

	// oscillator pin crosses in through two flops
	rct_sync2 #(
		.W        (1)
	) u_osc_sync (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_async  (i_osc_32k),
		.o_sync   (osc_sync)
	);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			osc_prev_reg <= 1'b0;
		else
			osc_prev_reg <= osc_sync;
	end

	assign osc_edge = osc_sync & ~osc_prev_reg;

	rct_tick_gen u_ticks (
		.i_clk       (i_clk),
		.i_resetn    (i_resetn),
		.i_osc_edge  (osc_edge),
		.i_corr_add  (i_corr_add),
		.i_corr_drop (i_corr_drop),
		.o_ticks     (ticks)
	);

	// apb decode
	always_comb begin
		mapped = (i_paddr == RCT_ADDR_TVAL) ||
			(i_paddr == RCT_ADDR_TMODE) || (i_paddr == RCT_ADDR_STAT);
	end

	assign setup    = i_psel & ~i_penable;
	assign commit   = i_psel & i_penable & o_pready & i_pwrite & mapped;
	assign wr_tval  = commit & (i_paddr == RCT_ADDR_TVAL);
	assign wr_tmode = commit & (i_paddr == RCT_ADDR_TMODE);
	assign wr_stat  = commit & (i_paddr == RCT_ADDR_STAT);

	// read mux; count read is live and may move under the read
	always_comb begin
		rdata = '0;
		case (i_paddr)
			RCT_ADDR_TVAL: begin
				rdata[7:0] = count_reg;
			end
			RCT_ADDR_TMODE: begin
				rdata[RCT_SEL_MSB:RCT_SEL_LSB] = mode_reg.src_sel;
				rdata[RCT_RUN_BIT]             = mode_reg.run;
				rdata[RCT_IEN_BIT]             = mode_reg.irq_en;
				rdata[RCT_PSEL_BIT]            = mode_reg.pulse_sel;
			end
			RCT_ADDR_STAT: begin
				rdata[RCT_FLAG_BIT] = flag_reg;
			end
			default: begin
				rdata = '0;
			end
		endcase
	end

	// one wait-free access phase per transfer
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= '0;
		end else begin
			o_pready  <= setup;
			o_pslverr <= setup & ~mapped;
			if (setup)
				o_prdata <= i_pwrite ? '0 : rdata;
		end
	end

	// control register
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mode_reg.src_sel   <= RCT_SEL_RST;
			mode_reg.run       <= RCT_BIT_RST;
			mode_reg.irq_en    <= RCT_BIT_RST;
			mode_reg.pulse_sel <= RCT_BIT_RST;
		end else if (wr_tmode) begin
			mode_reg.src_sel   <= i_pwdata[RCT_SEL_MSB:RCT_SEL_LSB];
			mode_reg.run       <= i_pwdata[RCT_RUN_BIT];
			mode_reg.irq_en    <= i_pwdata[RCT_IEN_BIT];
			mode_reg.pulse_sel <= i_pwdata[RCT_PSEL_BIT];
		end
	end

	// source tick selection
	always_comb begin
		case (mode_reg.src_sel)
			RCT_SRC_4096: src_tick = ticks.f4096;
			RCT_SRC_64:   src_tick = ticks.f64;
			RCT_SRC_1:    src_tick = ticks.f1;
			RCT_SRC_60TH: src_tick = ticks.f60;
			default:      src_tick = 1'b0;
		endcase
	end

	// slow sources arm on a 64 Hz edge, fast ones on their own tick
	assign sync_tick = mode_reg.src_sel[1] ? ticks.f64 : src_tick;

	// run takes effect only at a source-side edge, never mid tick
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			armed_reg <= 1'b0;
		else if (!mode_reg.run)
			armed_reg <= 1'b0;
		else if (sync_tick)
			armed_reg <= 1'b1;
	end

	// run gates the count directly: armed only drops one edge after stop
	assign expire = armed_reg & mode_reg.run & src_tick &
		(count_reg == 8'h01);

	// reload and count
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			reload_reg <= RCT_TVAL_RST;
			count_reg  <= RCT_TVAL_RST;
		end else if (wr_tval) begin
			reload_reg <= i_pwdata[7:0];
			count_reg  <= i_pwdata[7:0];
		end else if (armed_reg && mode_reg.run && src_tick &&
			count_reg != 8'h00) begin
			if (count_reg == 8'h01)
				count_reg <= reload_reg;
			else
				count_reg <= 8'(count_reg - 8'h01);
		end
	end

	// flag: hardware set wins over a clear in the same cycle
	assign flag_next = expire |
		(flag_reg & ~(wr_stat & i_pwdata[RCT_FLAG_BIT]));

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			flag_reg <= 1'b0;
		else
			flag_reg <= flag_next;
	end

	// pulse width in oscillator ticks
	always_comb begin
		case (mode_reg.src_sel)
			RCT_SRC_4096: pulse_width = (reload_reg == 8'h01) ?
				RCT_PW_W'(RCT_PW_FAST_T1) : RCT_PW_W'(RCT_PW_FAST);
			RCT_SRC_64: pulse_width = (reload_reg == 8'h01) ?
				RCT_PW_W'(RCT_PW_64_T1) : RCT_PW_W'(RCT_PW_64);
			default: pulse_width = RCT_PW_W'(RCT_PW_SLOW);
		endcase
	end

	always_comb begin
		pulse_next = pulse_reg;
		if (expire)
			pulse_next = pulse_width;
		else if (ticks.osc && pulse_reg != '0)
			pulse_next = RCT_PW_W'(pulse_reg - 1'b1);
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			pulse_reg <= '0;
		else
			pulse_reg <= pulse_next;
	end

	// output built from next values so flag and irq move together
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_irq_n          <= 1'b1;
			o_countdown_flag <= 1'b0;
		end else begin
			o_countdown_flag <= flag_next;
			if (!mode_reg.irq_en || !mode_reg.run)
				o_irq_n <= 1'b1;
			else if (mode_reg.pulse_sel)
				o_irq_n <= (pulse_next == '0);
			else
				o_irq_n <= ~flag_next;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	flag_sticky_a: assert property (
		flag_reg && !(wr_stat && i_pwdata[RCT_FLAG_BIT]) |=> flag_reg)
		else $error("countdown flag dropped without a clear");

	expiry_reload_a: assert property (
		expire && !wr_tval |=> flag_reg && count_reg == $past(reload_reg))
		else $error("expiry did not set flag and reload");

	count_step_a: assert property (
		armed_reg && src_tick && count_reg > 8'h01 && !wr_tval
		|=> count_reg == 8'($past(count_reg) - 8'h01))
		else $error("count did not step down by one");

	zero_stop_a: assert property (
		count_reg == 8'h00 && !wr_tval |=> count_reg == 8'h00 && !expire)
		else $error("zero count started running");

	stopped_hold_a: assert property (
		!mode_reg.run && !wr_tval && !wr_tmode
		|=> $stable(count_reg) && o_irq_n && !armed_reg)
		else $error("stopped timer moved or interrupted");

	reload_write_a: assert property (
		wr_tval |=> count_reg == $past(i_pwdata[7:0])
			&& reload_reg == $past(i_pwdata[7:0]))
		else $error("reload write not applied at once");

	same_edge_a: assert property (
		expire && mode_reg.irq_en && mode_reg.run && !wr_tmode
		|=> !o_irq_n && o_countdown_flag)
		else $error("flag and interrupt not asserted together");

	irq_off_a: assert property (
		!mode_reg.irq_en && !wr_tmode |=> o_irq_n)
		else $error("interrupt seen while disabled");

	pulse_fast_a: assert property (
		expire && mode_reg.src_sel == RCT_SRC_4096 && reload_reg > 8'h01
		|=> pulse_reg == RCT_PW_W'(RCT_PW_FAST))
		else $error("pulse width wrong at fast source");

	arm_wait_a: assert property (
		mode_reg.run && !armed_reg && !sync_tick |=> !armed_reg)
		else $error("run armed without a source edge");

	level_follow_a: assert property (
		mode_reg.irq_en && mode_reg.run && !mode_reg.pulse_sel
		&& !wr_tmode |=> o_irq_n == !o_countdown_flag)
		else $error("level interrupt not following flag");

endmodule // rct_countdown_timer

/* dv/rct_countdown_timer_tb.sv */
// self-checking bench for the countdown timer block
`timescale 1ns/100ps
module rct_countdown_timer_tb
	import rct_pkg::*;
;
	// design ports
	logic              i_clk;
	logic              i_resetn;
	logic              i_psel;
	logic              i_penable;
	logic              i_pwrite;
	logic [RCT_AW-1:0] i_paddr;
	logic [RCT_DW-1:0] i_pwdata;
	logic [RCT_DW-1:0] o_prdata;
	logic              o_pready;
	logic              o_pslverr;
	logic              i_osc_32k;
	logic              i_corr_add;
	logic              i_corr_drop;
	logic              o_irq_n;
	logic              o_countdown_flag;
	// bench state
	int                err_total;
	int                checks_done;
	int                cyc;
	int                nfall;
	int                last_fall;
	int                prev_fall;
	int                lo_run;
	int                last_w;
	int                div;
	int                s;
	logic              irq_q;
	logic [2:0]        osc_div;
	logic [31:0]       rd;
	logic [31:0]       rd2;
	logic              er;
	logic [7:0]        tvs [5];

	rct_countdown_timer i_rct_countdown_timer (
		.i_clk           (i_clk),
		.i_resetn        (i_resetn),
		.i_psel          (i_psel),
		.i_penable       (i_penable),
		.i_pwrite        (i_pwrite),
		.i_paddr         (i_paddr),
		.i_pwdata        (i_pwdata),
		.o_prdata        (o_prdata),
		.o_pready        (o_pready),
		.o_pslverr       (o_pslverr),
		.i_osc_32k       (i_osc_32k),
		.i_corr_add      (i_corr_add),
		.i_corr_drop     (i_corr_drop),
		.o_irq_n         (o_irq_n),
		.o_countdown_flag(o_countdown_flag)
	);

	always #20 i_clk = ~i_clk;

	// oscillator at one eighth of the clock to keep the run short
	always @(posedge i_clk) begin
		osc_div <= osc_div + 3'h1;
		i_osc_32k <= osc_div[2];
	end

	// irq falls and low widths in clock cycles
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		irq_q <= o_irq_n;
		if (irq_q && !o_irq_n) begin
			prev_fall <= last_fall;
			last_fall <= cyc;
			nfall <= nfall + 1;
		end
		if (!o_irq_n)
			lo_run <= irq_q ? 1 : lo_run + 1;
		else if (!irq_q)
			last_w <= lo_run;
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
			input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h want %h", $time, what,
				got, exp);
		end
	endtask

	task automatic give_up;
		err_total++;
		$display("unexpected at %0t: wait ran out", $time);
		tally_and_finish();
	endtask

	// one apb transfer, held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge i_clk);
		i_psel <= 1'h1;
		i_penable <= 1'h0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'h1;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		if (n >= 20)
			give_up();
		r = o_prdata;
		e = o_pslverr;
		i_psel <= 1'h0;
		i_penable <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, er);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
			input string what);
		apb(1'b0, a, 32'h0, rd, er);
		chk(rd, exp, what);
	endtask

	task automatic wait_flag(input logic exp_irq);
		int t;
		t = 0;
		while (o_countdown_flag !== 1'b1 && t < 40000) begin
			@(posedge i_clk);
			t++;
		end
		if (t >= 40000)
			give_up();
		chk({31'h0, o_irq_n}, {31'h0, exp_irq}, "irq at flag");
	endtask

	task automatic wait_falls(input int k);
		int t;
		int s0;
		t = 0;
		s0 = nfall;
		while ((nfall < s0 + k || o_irq_n !== 1'b1) && t < 40000) begin
			@(posedge i_clk);
			t++;
		end
		if (t >= 40000)
			give_up();
		// let the monitor's width update land
		@(posedge i_clk);
	endtask

	initial begin
		i_clk = 1'h0;
		i_resetn = 1'h0;
		{i_psel, i_penable, i_pwrite, i_osc_32k} = 4'h0;
		{i_corr_add, i_corr_drop} = 2'h0;
		i_paddr = 8'h00;
		i_pwdata = 32'h0;
		osc_div = 3'h0;
		irq_q = 1'h1;
		{err_total, checks_done, cyc, nfall} = '0;
		{last_fall, prev_fall, lo_run, last_w} = '0;
		tvs = '{8'h01, 8'h02, 8'h05, 8'h01, 8'h02};
		repeat (6) @(posedge i_clk);
		i_resetn <= 1'h1;

		rdc(RCT_ADDR_TVAL, 32'h0, "value reset");
		rdc(RCT_ADDR_TMODE, 32'h18, "mode reset");
		rdc(RCT_ADDR_STAT, 32'h0, "flag reset");
		apb(1'b0, 8'h4c, 32'h0, rd, er);
		chk({31'h0, er}, 32'h1, "unmapped err");
		chk(rd, 32'h0, "unmapped data");
		for (int i = 0; i < 4; i++) begin
			wr(RCT_ADDR_TMODE, 32'(i) << 3);
			rdc(RCT_ADDR_TMODE, 32'(i) << 3, "source code");
		end
		wr(RCT_ADDR_TVAL, 32'h5);
		rdc(RCT_ADDR_TVAL, 32'h5, "stopped load");
		repeat (300) @(posedge i_clk);
		rdc(RCT_ADDR_TVAL, 32'h5, "stopped hold");
		chk({31'h0, o_countdown_flag}, 32'h0, "stopped flag");
		$display("test registers done");

		// level mode, 4096 source
		wr(RCT_ADDR_TVAL, 32'h3);
		wr(RCT_ADDR_TMODE, 32'h06);
		wait_flag(1'b0);
		rdc(RCT_ADDR_TVAL, 32'h3, "reload after expiry");
		repeat (500) @(posedge i_clk);
		chk({31'h0, o_irq_n}, 32'h0, "level irq");
		wr(RCT_ADDR_TMODE, 32'h02);
		// irq output is registered from the new mode one edge later
		repeat (2) @(posedge i_clk);
		chk({31'h0, o_countdown_flag}, 32'h1, "flag sticky");
		chk({31'h0, o_irq_n}, 32'h1, "stopped irq");
		wr(RCT_ADDR_STAT, 32'h1);
		rdc(RCT_ADDR_STAT, 32'h0, "flag cleared");
		wr(RCT_ADDR_TMODE, 32'h04);
		wait_flag(1'b1);
		wr(RCT_ADDR_TMODE, 32'h00);
		wr(RCT_ADDR_STAT, 32'h1);
		$display("test level done");

		// pulse mode: periods and widths at both fast sources
		for (int i = 0; i < 5; i++) begin
			div = (i < 3) ? RCT_DIV_4096 : RCT_DIV_64;
			wr(RCT_ADDR_TVAL, {24'h0, tvs[i]});
			wr(RCT_ADDR_TMODE, (i < 3) ? 32'h07 : 32'h0f);
			wait_falls(3);
			chk(last_fall - prev_fall, tvs[i] * div * 8, "period");
			chk(last_w, ((tvs[i] == 1) ? div / 2 : div) * 8, "width");
			wr(RCT_ADDR_TMODE, 32'h00);
		end
		$display("test pulse done");

		// reload written while running
		wr(RCT_ADDR_TVAL, 32'h2);
		wr(RCT_ADDR_TMODE, 32'h07);
		wait_falls(1);
		wr(RCT_ADDR_TVAL, 32'h6);
		apb(1'b0, RCT_ADDR_TVAL, 32'h0, rd, er);
		chk({31'h0, rd == 32'h6 || rd == 32'h5}, 32'h1, "live load");
		wait_falls(3);
		chk(last_fall - prev_fall, 6 * RCT_DIV_4096 * 8, "new period");
		wr(RCT_ADDR_TVAL, 32'hc8);
		repeat (1000) @(posedge i_clk);
		apb(1'b0, RCT_ADDR_TVAL, 32'h0, rd, er);
		chk({31'h0, rd < 32'hc8 && rd > 32'h96}, 32'h1, "live count");
		rd2 = rd;
		apb(1'b0, RCT_ADDR_TVAL, 32'h0, rd, er);
		chk({31'h0, (rd2 - rd) < 32'h2}, 32'h1, "read twice");
		$display("test reload done");

		// zero reload stops the timer
		wr(RCT_ADDR_TVAL, 32'h0);
		wr(RCT_ADDR_STAT, 32'h1);
		s = nfall;
		repeat (2000) @(posedge i_clk);
		chk(nfall - s, 32'h0, "zero no irq");
		chk({31'h0, o_countdown_flag}, 32'h0, "zero no flag");
		rdc(RCT_ADDR_TVAL, 32'h0, "zero holds");
		$display("test zero done");

		// offset correction pulses reach the slow chain
		@(posedge i_clk);
		i_corr_drop <= 1'h1;
		@(posedge i_clk);
		i_corr_drop <= 1'h0;
		repeat (10) @(posedge i_clk);
		i_corr_add <= 1'h1;
		@(posedge i_clk);
		i_corr_add <= 1'h0;
		repeat (20) @(posedge i_clk);
		// unused timer parked at the slowest source
		wr(RCT_ADDR_TMODE, 32'h18);
		rdc(RCT_ADDR_TMODE, 32'h18, "parked source");
		$display("test park done");
		tally_and_finish();
	end
endmodule // rct_countdown_timer_tb
